/* src/dbg_port_pkg.sv */
// Constants shared by the one-wire debug command port and its helpers.
// Assumes a single 40 MHz system clock and a fixed agreed bit rate.
package dbg_port_pkg;

  localparam int          CLK_HZ          = 40_000_000;
  localparam int          BAUD_RATE       = 115_200;
  // Bit time rounded down to whole clock cycles
  localparam logic [15:0] BIT_CYCLES      = 16'(CLK_HZ / BAUD_RATE);
  localparam logic [15:0] HALF_BIT        = 16'(CLK_HZ / BAUD_RATE / 2);
  localparam logic [3:0]  FRAME_BITS      = 4'ha;
  localparam logic [3:0]  STOP_BIT        = 4'h9;

  localparam logic [7:0]  CMD_RD_PC       = 8'h07;
  localparam logic [7:0]  CMD_WR_REG      = 8'h08;
  localparam logic [7:0]  CMD_RD_REG      = 8'h09;
  localparam logic [7:0]  CMD_WR_MEM      = 8'h0a;
  localparam logic [7:0]  CMD_RD_MEM      = 8'h0b;

  localparam logic [7:0]  FILL_BYTE       = 8'hff;
  localparam logic [15:0] FILL_WORD       = 16'hffff;
  localparam logic [16:0] REG_SIZE_FULL   = 17'h00100;
  localparam logic [16:0] MEM_SIZE_FULL   = 17'h10000;
  localparam logic [16:0] PC_BYTES        = 17'h00002;

  // Register file window still writable under read protection
  localparam logic [11:0] FLASH_CTRL_FIRST = 12'hff8;
  localparam logic [11:0] FLASH_CTRL_LAST  = 12'hffb;

  localparam int          BYTE_W          = 8;
  localparam int          TX_FIFO_DEPTH   = 8;

endpackage

/* src/dbg_sync_fifo.sv */
// Small synchronous FIFO, width and depth set by parameters.
// Assumes one clock; push and pop may happen in the same cycle.
`timescale 1ns/1ps
module dbg_sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_i,      // System clock
  input  wire logic             rst_n_i,     // Sync reset, active low
  input  wire logic [WIDTH-1:0] in_data_i,   // Word to store
  input  wire logic             in_valid_i,  // Word offered
  output logic                  in_ready_o,  // Room for a word
  output logic      [WIDTH-1:0] out_data_o,  // Oldest word
  output logic                  out_valid_o, // FIFO not empty
  input  wire logic             out_ready_i  // Drain accepts word
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } fifo_s;

  fifo_s q;
  fifo_s d;
  logic  push;
  logic  pop;

  assign in_ready_o  = (q.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb
  begin
    d = q;
    if (push)
    begin
      d.mem[q.wr] = in_data_i;
      d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr + 1'b1);
    end
    if (pop)
    begin
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : AW'(q.rd + 1'b1);
    end
    if (push && !pop)
    begin
      d.cnt = (AW+1)'(q.cnt + 1'b1);
    end
    else if (pop && !push)
    begin
      d.cnt = (AW+1)'(q.cnt - 1'b1);
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end
endmodule // dbg_sync_fifo

/* src/dbg_serial_line.sv */
// Half-duplex asynchronous byte framer on one open-drain wire.
// Assumes an external pull-up; the pin input is asynchronous.
`timescale 1ns/1ps
module dbg_serial_line
  import dbg_port_pkg::*;
(
  input  wire logic       mclk_i,     // System clock
  input  wire logic       rst_n_i,    // Sync reset, active low
  input  wire logic       pin_i,      // Wire level
  output logic            pin_o,      // Driven level, always low
  output logic            pin_oe_o,   // High while pulling low
  output logic [7:0]      rx_data_o,  // Received byte
  output logic            rx_valid_o, // One-cycle pulse per byte
  input  wire logic [7:0] tx_data_i,  // Byte to send
  input  wire logic       tx_valid_i, // Byte offered
  output logic            tx_ready_o  // Line idle, byte taken
);
  typedef struct packed {
    logic [2:0]  sync;
    logic        lvl;
    logic        rx_on;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        tx_on;
    logic [15:0] tx_cnt;
    logic [3:0]  tx_bit;
    logic [9:0]  tx_sh;
    logic        drive;
  } line_s;

  line_s q;
  line_s d;

  assign pin_o      = 1'b0;
  assign pin_oe_o   = q.drive;
  assign rx_data_o  = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  // RULE2: no send once rx_on is set, but a send can start in the same cycle that reception starts
  assign tx_ready_o = !q.tx_on && !q.rx_on && q.lvl;

  always_comb
  begin
    d          = q;
    d.rx_valid = 1'b0;
    d.sync     = {q.sync[1:0], pin_i};
    // Only the agreed later stages decide the level
    if (q.sync[1] == q.sync[2])
    begin
      d.lvl = q.sync[2];
    end
    // RULE4: start, 8 bits LSB first, stop
    if (!q.rx_on)
    begin
      // RULE2: own echo ignored while sending
      if (!q.tx_on && q.lvl && (q.sync[1] == q.sync[2]) && !q.sync[2])
      begin
        d.rx_on  = 1'b1;
        d.rx_cnt = HALF_BIT;
        d.rx_bit = '0;
      end
    end
    else if (q.rx_cnt != '0)
    begin
      d.rx_cnt = 16'(q.rx_cnt - 1'b1);
    end
    else
    begin
      d.rx_cnt = 16'(BIT_CYCLES - 1'b1);
      d.rx_bit = 4'(q.rx_bit + 1'b1);
      if (q.rx_bit == '0)
      begin
        // False start: line went back high
        d.rx_on = !q.lvl;
      end
      else if (q.rx_bit == STOP_BIT)
      begin
        d.rx_on = 1'b0;
        // RULE3: framing error drops the byte
        if (q.lvl)
        begin
          d.rx_data  = q.rx_sh;
          d.rx_valid = 1'b1;
        end
      end
      else
      begin
        d.rx_sh = {q.lvl, q.rx_sh[7:1]};
      end
    end
    if (tx_valid_i && tx_ready_o)
    begin
      d.tx_on  = 1'b1;
      d.tx_sh  = {1'b1, tx_data_i, 1'b0};
      d.tx_bit = '0;
      d.tx_cnt = 16'(BIT_CYCLES - 1'b1);
    end
    else if (q.tx_on)
    begin
      if (q.tx_cnt != '0)
      begin
        d.tx_cnt = 16'(q.tx_cnt - 1'b1);
      end
      else
      begin
        d.tx_cnt = 16'(BIT_CYCLES - 1'b1);
        d.tx_sh  = {1'b1, q.tx_sh[9:1]};
        d.tx_bit = 4'(q.tx_bit + 1'b1);
        d.tx_on  = (q.tx_bit != 4'(FRAME_BITS - 1'b1));
      end
    end
    // RULE1: only ever pull low, else release
    d.drive = d.tx_on && !d.tx_sh[0];
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      q      <= '0;
      q.sync <= 3'h7;
      q.lvl  <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end
endmodule // dbg_serial_line

/* src/dbg_command_port.sv */
// Debug command decoder behind the one-wire serial debug pin.
// Assumes register file and program memory answer one cycle after a read strobe.
// Contract
// RULE1: Debug traffic uses one open-drain two-way pin, each side only pulling it low.
// RULE2: The link is half-duplex, so the device never sends while it receives. The code can start a send in the cycle a start bit is detected.
// RULE3: Bytes use standard asynchronous framing with start and stop bits.
// RULE4: Each character is one start bit, eight data bits LSB first, no parity, one stop bit.
// RULE5: Command 07H returns the program counter high byte, then the low byte.
// RULE6: Outside debug mode or under read protection the counter reads as FFFFH.
// RULE7: Register writes arrive as 08H, zero-padded address high, address low, size, data.
// RULE8: Register transfers run 1 to 256 bytes, a zero size meaning 256.
// RULE9: Outside debug mode register write address and data are dropped.
// RULE10: Under read protection only flash control registers may be written.
// RULE11: Command 09H with padded address, low address and size returns that many bytes.
// RULE12: A blocked register read returns FFH for every byte.
// RULE13: Program memory writes arrive as 0AH, address high, low, size high, low, data.
// RULE14: Program memory is written only while the flash controller is unlocked.
// RULE15: Program memory writes are dropped outside debug mode or under read protection.
// RULE16: Command 0BH reads 1 to 65536 program memory bytes, a zero size meaning 65536.
// RULE17: A blocked program memory read returns FFH for every byte.
`timescale 1ns/1ps
module dbg_command_port
  import dbg_port_pkg::*;
(
  input  wire logic        mclk_i,                // System clock, 40 MHz
  input  wire logic        rst_n_i,               // Sync reset, active low
  input  wire logic        debug_serial_pin_i,    // Debug wire level
  output logic             debug_serial_pin_o,    // Debug wire drive value
  output logic             debug_serial_pin_oe_o, // High while pulling wire low
  input  wire logic        debug_mode_i,          // Core is in debug mode
  input  wire logic        read_protect_i,        // Flash read protection on
  input  wire logic        flash_unlocked_i,      // Flash controller unlocked
  input  wire logic [15:0] pc_i,                  // Core program counter
  output logic      [11:0] reg_addr_o,            // Register file address
  output logic      [7:0]  reg_wdata_o,           // Register write data
  output logic             reg_we_o,              // Register write strobe
  output logic             reg_re_o,              // Register read strobe
  input  wire logic [7:0]  reg_rdata_i,           // Register data, cycle after strobe
  output logic      [15:0] mem_addr_o,            // Program memory address
  output logic      [7:0]  mem_wdata_o,           // Program memory write data
  output logic             mem_we_o,              // Program memory write strobe
  output logic             mem_re_o,              // Program memory read strobe
  input  wire logic [7:0]  mem_rdata_i            // Memory data, cycle after strobe
);
  typedef enum logic [3:0] {
    S_IDLE    = 4'h0,
    S_ADDR_HI = 4'h1,
    S_ADDR_LO = 4'h2,
    S_SIZE_HI = 4'h3,
    S_SIZE_LO = 4'h4,
    S_WRITE   = 4'h5,
    S_RD_REQ  = 4'h6,
    S_RD_WAIT = 4'h7,
    S_RD_CAP  = 4'h8,
    S_PUSH    = 4'h9
  } cmd_state_e;

  typedef struct packed {
    cmd_state_e  state;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [16:0] count;
    logic [7:0]  size_hi;
    logic [7:0]  pc_lo;
    logic [7:0]  byte_out;
    logic [15:0] bus_addr;
    logic [7:0]  wdata;
    logic        reg_we;
    logic        reg_re;
    logic        mem_we;
    logic        mem_re;
  } port_s;

  port_s      q;
  port_s      d;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       push_valid;
  logic       push_ready;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic       blocked;
  logic       reg_cmd;

  // Register file commands carry 12-bit addresses and 8-bit sizes
  function automatic logic is_reg_cmd(input logic [7:0] cmd);
    return (cmd == CMD_WR_REG) || (cmd == CMD_RD_REG);
  endfunction

  function automatic logic [16:0] expand_size(input logic [15:0] size, input logic is_reg);
    logic [16:0] res;
    res = {1'b0, size};
    // RULE8: zero size means 256
    if (is_reg && (size[7:0] == 8'h00))
    begin
      res = REG_SIZE_FULL;
    end
    // RULE16: zero size means 65536
    else if (!is_reg && (size == 16'h0000))
    begin
      res = MEM_SIZE_FULL;
    end
    return res;
  endfunction

  function automatic logic [15:0] next_addr(input logic [15:0] addr, input logic is_reg);
    logic [15:0] inc;
    inc = 16'(addr + 1'b1);
    // Register window wraps inside its 12-bit space
    return is_reg ? {4'h0, inc[11:0]} : inc;
  endfunction

  function automatic logic in_flash_ctrl(input logic [11:0] addr);
    return (addr >= FLASH_CTRL_FIRST) && (addr <= FLASH_CTRL_LAST);
  endfunction

  assign blocked     = !debug_mode_i || read_protect_i;
  assign reg_cmd     = is_reg_cmd(q.cmd);
  assign push_valid  = (q.state == S_PUSH);
  assign reg_addr_o  = q.bus_addr[11:0];
  assign mem_addr_o  = q.bus_addr;
  assign reg_wdata_o = q.wdata;
  assign mem_wdata_o = q.wdata;
  assign reg_we_o    = q.reg_we;
  assign reg_re_o    = q.reg_re;
  assign mem_we_o    = q.mem_we;
  assign mem_re_o    = q.mem_re;

  always_comb
  begin
    d        = q;
    d.reg_we = 1'b0;
    d.reg_re = 1'b0;
    d.mem_we = 1'b0;
    d.mem_re = 1'b0;
    unique case (q.state)
      S_IDLE:
      begin
        if (rx_valid)
        begin
          d.cmd = rx_data;
          unique case (rx_data)
            CMD_RD_PC:
            begin
              // RULE5: high byte first
              d.byte_out = pc_i[15:8];
              d.pc_lo    = pc_i[7:0];
              // RULE6: filler counter value
              if (blocked)
              begin
                d.byte_out = FILL_WORD[15:8];
                d.pc_lo    = FILL_WORD[7:0];
              end
              d.count = PC_BYTES;
              d.state = S_PUSH;
            end
            CMD_WR_REG, CMD_RD_REG, CMD_WR_MEM, CMD_RD_MEM:
            begin
              d.state = S_ADDR_HI;
            end
            default:
            begin
              d.state = S_IDLE;
            end
          endcase
        end
      end
      S_ADDR_HI:
      begin
        if (rx_valid)
        begin
          // RULE7: upper nibble of padded byte ignored
          d.addr[15:8] = reg_cmd ? {4'h0, rx_data[3:0]} : rx_data;
          d.state      = S_ADDR_LO;
        end
      end
      S_ADDR_LO:
      begin
        if (rx_valid)
        begin
          d.addr[7:0] = rx_data;
          d.size_hi   = 8'h00;
          // RULE13: memory commands carry a 16-bit size
          d.state     = reg_cmd ? S_SIZE_LO : S_SIZE_HI;
        end
      end
      S_SIZE_HI:
      begin
        if (rx_valid)
        begin
          d.size_hi = rx_data;
          d.state   = S_SIZE_LO;
        end
      end
      S_SIZE_LO:
      begin
        if (rx_valid)
        begin
          d.count = expand_size({q.size_hi, rx_data}, reg_cmd);
          // RULE11: reads answer with data bytes
          if ((q.cmd == CMD_RD_REG) || (q.cmd == CMD_RD_MEM))
          begin
            d.state = S_RD_REQ;
          end
          else
          begin
            d.state = S_WRITE;
          end
        end
      end
      S_WRITE:
      begin
        if (rx_valid)
        begin
          d.bus_addr = q.addr;
          d.wdata    = rx_data;
          if (reg_cmd)
          begin
            // RULE9: dropped outside debug mode
            // RULE10: protection leaves only flash control
            d.reg_we = debug_mode_i && (!read_protect_i || in_flash_ctrl(q.addr[11:0]));
          end
          else
          begin
            // RULE14: needs unlocked flash controller
            // RULE15: dropped when blocked
            d.mem_we = !blocked && flash_unlocked_i;
          end
          d.addr  = next_addr(q.addr, reg_cmd);
          d.count = 17'(q.count - 1'b1);
          // RULE8: stop after the last counted byte
          if (q.count == 17'h00001)
          begin
            d.state = S_IDLE;
          end
        end
      end
      S_RD_REQ:
      begin
        d.bus_addr = q.addr;
        // Blocked reads never touch the array
        d.reg_re   = reg_cmd && !blocked;
        d.mem_re   = !reg_cmd && !blocked;
        d.state    = S_RD_WAIT;
      end
      S_RD_WAIT:
      begin
        d.state = S_RD_CAP;
      end
      S_RD_CAP:
      begin
        // RULE16: byte as a constant-memory load reads it
        d.byte_out = reg_cmd ? reg_rdata_i : mem_rdata_i;
        // RULE12: register filler
        // RULE17: memory filler
        if (blocked)
        begin
          d.byte_out = FILL_BYTE;
        end
        d.state = S_PUSH;
      end
      S_PUSH:
      begin
        // FIFO full stalls the read loop
        if (push_ready)
        begin
          d.count = 17'(q.count - 1'b1);
          if (q.count == 17'h00001)
          begin
            d.state = S_IDLE;
          end
          else if (q.cmd == CMD_RD_PC)
          begin
            // RULE5: low byte second
            d.byte_out = q.pc_lo;
          end
          else
          begin
            d.addr  = next_addr(q.addr, reg_cmd);
            d.state = S_RD_REQ;
          end
        end
      end
      default:
      begin
        d.state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // Decouples the read loop from the slow serial rate
  dbg_sync_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (q.byte_out),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .out_data_o  (tx_data),
    .out_valid_o (tx_valid),
    .out_ready_i (tx_ready)
  );

  // RULE1: open-drain wire handling
  // RULE3: asynchronous character framing
  dbg_serial_line u_line (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      (debug_serial_pin_i),
    .pin_o      (debug_serial_pin_o),
    .pin_oe_o   (debug_serial_pin_oe_o),
    .rx_data_o  (rx_data),
    .rx_valid_o (rx_valid),
    .tx_data_i  (tx_data),
    .tx_valid_i (tx_valid),
    .tx_ready_o (tx_ready)
  );
endmodule // dbg_command_port

/* test/dbg_command_port_chk.sv */
// Checker for the debug command port, bound to its top module.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/1ps
module dbg_command_port_chk
  import dbg_port_pkg::*;
(
  input wire logic        mclk_i,                // Clock
  input wire logic        rst_n_i,               // Reset
  input wire logic        debug_serial_pin_i,    // Wire
  input wire logic        debug_serial_pin_o,    // Drive
  input wire logic        debug_serial_pin_oe_o, // Pull
  input wire logic        debug_mode_i,          // Debug
  input wire logic        read_protect_i,        // Protect
  input wire logic        flash_unlocked_i,      // Unlock
  input wire logic [15:0] pc_i,                  // Counter
  input wire logic [11:0] reg_addr_o,            // Reg addr
  input wire logic [7:0]  reg_wdata_o,           // Reg data
  input wire logic        reg_we_o,              // Reg write
  input wire logic        reg_re_o,              // Reg read
  input wire logic [7:0]  reg_rdata_i,           // Reg rdata
  input wire logic [15:0] mem_addr_o,            // Mem addr
  input wire logic [7:0]  mem_wdata_o,           // Mem data
  input wire logic        mem_we_o,              // Mem write
  input wire logic        mem_re_o,              // Mem read
  input wire logic [7:0]  mem_rdata_i            // Mem rdata
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // Cycles the device has held the wire low
  logic [15:0] low_run_q;
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i || !debug_serial_pin_oe_o)
      low_run_q <= 16'h0000;
    else
      low_run_q <= low_run_q + 16'h0001;
  end

  chk_drive_only_low: assert property (debug_serial_pin_o == 1'b0)
    else $error("pin drive value not low");
  chk_no_talk_over: assert property (
    !debug_serial_pin_i && !debug_serial_pin_oe_o |=> !debug_serial_pin_oe_o)
    else $error("device pulled wire while host sent");
  chk_bit_length: assert property (
    $fell(debug_serial_pin_oe_o) |-> low_run_q != 16'h0000
      && low_run_q % BIT_CYCLES == 16'h0000 && low_run_q <= BIT_CYCLES * 16'h0009)
    else $error("low run not whole bits");
  chk_reg_wr_mode: assert property (reg_we_o |-> $past(debug_mode_i))
    else $error("register write outside debug mode");
  chk_reg_wr_window: assert property (
    reg_we_o && $past(read_protect_i)
      |-> reg_addr_o inside {[FLASH_CTRL_FIRST:FLASH_CTRL_LAST]})
    else $error("protected register write outside window");
  chk_mem_wr_lock: assert property (mem_we_o |-> $past(flash_unlocked_i))
    else $error("memory write while flash locked");
  chk_mem_wr_mode: assert property (
    mem_we_o |-> $past(debug_mode_i) && !$past(read_protect_i))
    else $error("memory write while blocked");
  chk_reg_rd_block: assert property (
    reg_re_o |-> $past(debug_mode_i) && !$past(read_protect_i))
    else $error("register read strobe while blocked");
  chk_mem_rd_block: assert property (
    mem_re_o |-> $past(debug_mode_i) && !$past(read_protect_i))
    else $error("memory read strobe while blocked");
endmodule // dbg_command_port_chk

bind dbg_command_port dbg_command_port_chk i_dbg_command_port_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .debug_serial_pin_i(debug_serial_pin_i),
  .debug_serial_pin_o(debug_serial_pin_o), .debug_serial_pin_oe_o(debug_serial_pin_oe_o),
  .debug_mode_i(debug_mode_i), .read_protect_i(read_protect_i),
  .flash_unlocked_i(flash_unlocked_i), .pc_i(pc_i), .reg_addr_o(reg_addr_o),
  .reg_wdata_o(reg_wdata_o), .reg_we_o(reg_we_o), .reg_re_o(reg_re_o),
  .reg_rdata_i(reg_rdata_i), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_rdata_i(mem_rdata_i)
);

/* test/dbg_host_model.sv */
// Behavioural debug host on the open-drain serial wire.
// Assumes the bench resolves the wire with a pull-up.
`timescale 1ns/1ps
module dbg_host_model
  import dbg_port_pkg::*;
(
  input  wire logic mclk_i,   // Clock
  input  wire logic line_i,   // Wire level
  output logic      host_oe_o // High while pulling low
);
  logic [7:0] rxq[$];
  logic [7:0] rx_b;
  int         i;

  initial host_oe_o = 1'b0;

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int k = 0; k < 10; k++)
    begin
      host_oe_o = ~f[k];
      repeat (BIT_CYCLES) @(negedge mclk_i);
    end
  endtask

  always
  begin
    // Rising edge: clear of the host's own falling-edge drive changes
    @(posedge mclk_i);
    if (!line_i && !host_oe_o)
    begin
      repeat (HALF_BIT) @(negedge mclk_i);
      for (i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(negedge mclk_i);
        rx_b[i] = line_i;
      end
      repeat (BIT_CYCLES) @(negedge mclk_i);
      // Bad stop bit drops the byte
      if (line_i)
        rxq.push_back(rx_b);
    end
  end

  task automatic recv_byte(output logic [7:0] b, output logic ok);
    ok = 1'b0;
    b = 8'h00;
    for (int n = 0; n < 16 * BIT_CYCLES && !ok; n++)
    begin
      @(negedge mclk_i);
      if (rxq.size() > 0)
      begin
        b = rxq.pop_front();
        ok = 1'b1;
        repeat (HALF_BIT + 16'h0008) @(negedge mclk_i);
      end
    end
  endtask
endmodule // dbg_host_model

/* test/tb_dbg_command_port.sv */
// Self-checking bench for the debug command port.
// Assumes the host model and the port's package constants.
`timescale 1ns/1ps
module tb_dbg_command_port
  import dbg_port_pkg::*;
;
  logic        mclk_i, rst_n_i, dbg_wire, dev_oe, host_oe, drv;
  logic        dbg_on, prot, unlk, reg_we, reg_re, mem_we, mem_re;
  logic [15:0] pc, mem_addr, wr_addr;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, mem_wdata, mem_rdata, wr_data;
  int          n_fail, checked, n_reg_wr, n_mem_wr;

  // pull-up, low when either side pulls
  assign dbg_wire = ~(dev_oe | host_oe);

  dbg_command_port i_dbg_command_port (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .debug_serial_pin_i(dbg_wire),
    .debug_serial_pin_o(drv), .debug_serial_pin_oe_o(dev_oe), .debug_mode_i(dbg_on),
    .read_protect_i(prot), .flash_unlocked_i(unlk), .pc_i(pc), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_we_o(reg_we), .reg_re_o(reg_re), .reg_rdata_i(reg_rdata),
    .mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_we_o(mem_we), .mem_re_o(mem_re),
    .mem_rdata_i(mem_rdata)
  );
  dbg_host_model i_dbg_host_model (.mclk_i(mclk_i), .line_i(dbg_wire), .host_oe_o(host_oe));

  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Read data held until the next strobe
  always @(negedge mclk_i)
  begin
    if (reg_re)
      reg_rdata <= reg_addr[7:0] ^ 8'ha5;
    if (mem_re)
      mem_rdata <= {mem_addr[3:0], mem_addr[15:12]} ^ 8'h3c;
    if (reg_we)
    begin
      n_reg_wr <= n_reg_wr + 1;
      wr_addr <= {4'h0, reg_addr};
      wr_data <= reg_wdata;
    end
    if (mem_we)
    begin
      n_mem_wr <= n_mem_wr + 1;
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
  end

  task automatic test_done();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input logic [7:0] b);
    i_dbg_host_model.send_byte(b);
  endtask

  task automatic expect_byte(input logic [7:0] exp);
    logic [7:0] b;
    logic       ok;
    i_dbg_host_model.recv_byte(b, ok);
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, b, exp);
      test_done();
    end
    else
      check({8'h00, b}, {8'h00, exp});
  endtask

  task automatic t_pc_read();
    pc = 16'h5a3c;
    send(CMD_RD_PC);
    expect_byte(8'h5a);
    expect_byte(8'h3c);
  endtask

  // First byte outside the flash window, second inside
  task automatic t_reg_write();
    prot = 1'b1;
    send(CMD_WR_REG);
    send(8'h0f);
    send(8'hf7);
    send(8'h02);
    send(8'h11);
    send(8'h22);
    check(16'(n_reg_wr), 16'h0001);
    check(wr_addr, 16'h0ff8);
    check({8'h00, wr_data}, 16'h0022);
    prot = 1'b0;
  endtask

  task automatic t_reg_read_blocked();
    dbg_on = 1'b0;
    send(CMD_RD_REG);
    send(8'h01);
    send(8'h23);
    send(8'h01);
    expect_byte(FILL_BYTE);
    dbg_on = 1'b1;
  endtask

  // Unlock arrives between the two data bytes
  task automatic t_mem_write();
    send(CMD_WR_MEM);
    send(8'h12);
    send(8'h34);
    send(8'h00);
    send(8'h02);
    send(8'hd0);
    unlk = 1'b1;
    send(8'hd1);
    check(16'(n_mem_wr), 16'h0001);
    check(wr_addr, 16'h1235);
    check({8'h00, wr_data}, 16'h00d1);
  endtask

  // Address wraps from the top of memory
  task automatic t_mem_read_wrap();
    send(CMD_RD_MEM);
    send(8'hff);
    send(8'hff);
    send(8'h00);
    send(8'h02);
    expect_byte(8'hc3);
    expect_byte(8'h3c);
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    dbg_on = 1'b1;
    prot = 1'b0;
    unlk = 1'b0;
    pc = 16'h0000;
    reg_rdata = 8'h00;
    mem_rdata = 8'h00;
    n_fail = 0;
    checked = 0;
    n_reg_wr = 0;
    n_mem_wr = 0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_pc_read();
    t_reg_write();
    t_reg_read_blocked();
    t_mem_write();
    t_mem_read_wrap();
    test_done();
  end
endmodule // tb_dbg_command_port
